// *** include/gsbt_pkg.sv ***
// Purpose: shared constants of the gated 16-bit timer
// Assumes: 8-bit register port, one core clock
// Notes:   offsets are word indexes on the plain register port
package gsbt_pkg;
	// ****************************************
	// widths and offsets
	// ****************************************
	localparam int unsigned ADDR_W     = 3;
	localparam int unsigned DATA_W     = 8;
	localparam logic [2:0] OFS_CTRL     = 3'h0;
	localparam logic [2:0] OFS_GATE     = 3'h1;
	localparam logic [2:0] OFS_CNT_LO   = 3'h2;
	localparam logic [2:0] OFS_CNT_HI   = 3'h3;
	localparam logic [2:0] OFS_STATUS   = 3'h4;
	localparam logic [2:0] OFS_MASK     = 3'h5;
	localparam logic [2:0] OFS_IRQ_CTRL = 3'h6;
	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned CTRL_RUN    = 0;
	localparam int unsigned CTRL_BYPASS = 2;
	localparam int unsigned CTRL_PS_LSB = 4;
	localparam int unsigned CTRL_CS_LSB = 6;
	localparam int unsigned GATE_ON     = 7;
	localparam int unsigned GATE_POL    = 6;
	localparam int unsigned GATE_TOGGLE = 5;
	localparam int unsigned GATE_SPM    = 4;
	localparam int unsigned GATE_ARMED  = 3;
	localparam int unsigned GATE_LEVEL  = 2;
	localparam int unsigned ST_OVF      = 0;
	localparam int unsigned ST_GATE     = 1;
	localparam int unsigned IC_PERIPH   = 0;
	localparam int unsigned IC_GLOBAL   = 1;
	// ****************************************
	// reset values, masks and codes
	// ****************************************
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [7:0]  CTRL_RW_MASK = 8'hf5;
	localparam logic [7:0]  GATE_RESET   = 8'h00;
	localparam logic [7:0]  GATE_RW_MASK = 8'hf0;
	localparam logic [15:0] CNT_RESET    = 16'h0000;
	localparam logic [15:0] CNT_MAX      = 16'hffff;
	localparam logic [1:0]  FLAG_RESET   = 2'h0;
	localparam logic [1:0]  CS_SYS_DIV4  = 2'h0;
	localparam logic [1:0]  CS_SYS       = 2'h1;
	localparam logic [1:0]  CS_EXT_PIN   = 2'h2;
	localparam logic [1:0]  CS_LF_OSC    = 2'h3;
	localparam logic [1:0]  PHASE_LAST   = 2'h3;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned SYS_DIV       = 4;
endpackage

// *** rtl/gsbt_sync.sv ***
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input asynchronous to core_clk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
module gsbt_sync (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output logic      level
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			level  <= 1'b0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				level <= stage3;
			end
		end
	end
endmodule

// *** rtl/gsbt_prescale.sv ***
// Purpose: divide a tick stream by 1, 2, 4 or 8
// Assumes: tick_in is one cycle long
// Notes:   clear restarts the division
`timescale 1ns/1ps
module gsbt_prescale #(
	parameter int unsigned PS_W = 3
) (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       clear,
	input  wire logic       tick_in,
	input  wire logic [1:0] ratio_sel,
	output logic            tick_out
);
	logic [PS_W-1:0] count;
	logic [PS_W-1:0] ratio_mask;

	function automatic logic [PS_W-1:0] mask_of(input logic [1:0] sel);
		mask_of = PS_W'((4'h1 << sel) - 4'h1);
	endfunction

	assign ratio_mask = mask_of(ratio_sel);
	assign tick_out   = tick_in && ((count & ratio_mask) == ratio_mask);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (tick_in) begin
			count <= count + PS_W'(1);
		end
	end
endmodule

// *** rtl/gsbt_timer.sv ***
// Purpose: gated 16-bit timer with overflow and gate event interrupts
// Assumes: register port on core_clk; pins pass three-stage synchronisers
// Notes:   in sleep only the unsynchronised external pin source counts
`timescale 1ns/1ps
module gsbt_timer (
	input  wire logic                         core_clk,
	input  wire logic                         rst_b,
	input  wire logic [gsbt_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [gsbt_pkg::DATA_W-1:0]  reg_wr_data,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [gsbt_pkg::DATA_W-1:0]  reg_rd_data,
	input  wire logic                         external_clock_pin,
	input  wire logic                         low_freq_internal_osc,
	input  wire logic                         gate_pin,
	input  wire logic                         sleep_mode,
	output logic                              irq,
	output logic                              wake,
	output logic                              ext_osc_enable
);
	// ****************************************
	// state
	// ****************************************
	logic [7:0]  timer_control_register;
	logic [7:0]  gate_control;
	logic [15:0] count;
	logic        overflow_flag;
	logic        gate_event_flag;
	logic        overflow_irq_enable;
	logic        gate_event_irq_enable;
	logic        peripheral_irq_enable;
	logic        global_irq_enable;
	logic        gate_level;
	logic        gate_src_prev;
	logic        toggle_ff;
	logic        ext_prev;
	logic        lf_prev;
	logic        ext_pending;
	logic [1:0]  phase;
	logic [7:0]  next_rd_data;

	// ****************************************
	// field views and decode
	// ****************************************
	wire logic       timer_run           = timer_control_register[gsbt_pkg::CTRL_RUN];
	wire logic       sync_bypass         = timer_control_register[gsbt_pkg::CTRL_BYPASS];
	wire logic [1:0] prescale_select     = timer_control_register[gsbt_pkg::CTRL_PS_LSB +: 2];
	wire logic [1:0] clock_source_select = timer_control_register[gsbt_pkg::CTRL_CS_LSB +: 2];
	wire logic       gating_on           = gate_control[gsbt_pkg::GATE_ON];
	wire logic       gate_polarity       = gate_control[gsbt_pkg::GATE_POL];
	wire logic       toggle_gate_mode    = gate_control[gsbt_pkg::GATE_TOGGLE];
	wire logic       single_pulse_mode   = gate_control[gsbt_pkg::GATE_SPM];
	wire logic       pulse_acquire_armed = gate_control[gsbt_pkg::GATE_ARMED];

	wire logic       wr_ctrl             = reg_wr && (reg_addr == gsbt_pkg::OFS_CTRL);
	wire logic       wr_gate             = reg_wr && (reg_addr == gsbt_pkg::OFS_GATE);
	wire logic       wr_lo               = reg_wr && (reg_addr == gsbt_pkg::OFS_CNT_LO);
	wire logic       wr_hi               = reg_wr && (reg_addr == gsbt_pkg::OFS_CNT_HI);
	wire logic       wr_status           = reg_wr && (reg_addr == gsbt_pkg::OFS_STATUS);
	wire logic       wr_mask             = reg_wr && (reg_addr == gsbt_pkg::OFS_MASK);
	wire logic       wr_irq_ctrl         = reg_wr && (reg_addr == gsbt_pkg::OFS_IRQ_CTRL);
	wire logic       sw_arm              = wr_gate && reg_wr_data[gsbt_pkg::GATE_ARMED];

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic ext_level;
	logic lf_level;
	logic gate_in;

	gsbt_sync u_sync_ext (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pin_in   (external_clock_pin),
		.level    (ext_level)
	);
	gsbt_sync u_sync_lf (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pin_in   (low_freq_internal_osc),
		.level    (lf_level)
	);
	gsbt_sync u_sync_gate (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pin_in   (gate_pin),
		.level    (gate_in)
	);

	// ****************************************
	// gate path
	// ****************************************
	wire logic gate_src   = gate_polarity ? gate_in : !gate_in;
	wire logic gate_value = toggle_gate_mode ? toggle_ff : gate_src;
	wire logic gate_fall  = gate_level && !gate_value;
	wire logic gate_open  = !single_pulse_mode || pulse_acquire_armed;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gate_level    <= 1'b0;
			gate_src_prev <= 1'b0;
			toggle_ff     <= 1'b0;
		end else begin
			gate_level    <= gate_value;
			gate_src_prev <= gate_src;
			if (!timer_run || !toggle_gate_mode) begin
				toggle_ff <= 1'b0;
			end else if (gate_src && !gate_src_prev) begin
				toggle_ff <= !toggle_ff;
			end
		end
	end

	// ****************************************
	// clock source and tick selection
	// ****************************************
	logic      inc;

	wire logic ext_rise  = ext_level && !ext_prev;
	wire logic lf_rise   = lf_level && !lf_prev;
	wire logic phase_end = (phase == gsbt_pkg::PHASE_LAST);
	// bypass counts at once; otherwise the edge waits for the instruction phase
	wire logic ext_tick  = sync_bypass ? ext_rise :
		((ext_pending || ext_rise) && phase_end);
	wire logic src_tick  = sleep_mode ?
		((clock_source_select == gsbt_pkg::CS_EXT_PIN) && sync_bypass && ext_rise) :
		(clock_source_select == gsbt_pkg::CS_LF_OSC)  ? lf_rise :
		(clock_source_select == gsbt_pkg::CS_EXT_PIN) ? ext_tick :
		(clock_source_select == gsbt_pkg::CS_SYS)     ? 1'b1 :
		phase_end;
	wire logic count_en  = timer_run && (!gating_on || (gate_level && gate_open));
	wire logic pre_clear = wr_lo || wr_hi || !timer_run;

	gsbt_prescale #(
		.PS_W (3)
	) u_prescale (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.clear     (pre_clear),
		.tick_in   (src_tick && count_en),
		.ratio_sel (prescale_select),
		.tick_out  (inc)
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_prev    <= 1'b0;
			lf_prev     <= 1'b0;
			ext_pending <= 1'b0;
			phase       <= 2'h0;
		end else begin
			ext_prev    <= ext_level;
			lf_prev     <= lf_level;
			phase       <= phase + 2'h1;
			ext_pending <= !sync_bypass && !phase_end && (ext_pending || ext_rise);
		end
	end

	// ****************************************
	// counter and flags
	// ****************************************
	wire logic ovf_evt = inc && (count == gsbt_pkg::CNT_MAX) && !wr_lo && !wr_hi;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= gsbt_pkg::CNT_RESET;
		end else if (wr_lo) begin
			count[7:0] <= reg_wr_data;
		end else if (wr_hi) begin
			count[15:8] <= reg_wr_data;
		end else if (inc) begin
			count <= count + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			overflow_flag   <= 1'b0;
			gate_event_flag <= 1'b0;
		end else begin
			// set wins over a write-one clear
			overflow_flag   <= ovf_evt ||
				(overflow_flag && !(wr_status && reg_wr_data[gsbt_pkg::ST_OVF]));
			gate_event_flag <= gate_fall ||
				(gate_event_flag && !(wr_status && reg_wr_data[gsbt_pkg::ST_GATE]));
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	wire logic [7:0] gate_sw = (gate_control & ~gsbt_pkg::GATE_RW_MASK) |
		(reg_wr_data & gsbt_pkg::GATE_RW_MASK);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_control_register <= gsbt_pkg::CTRL_RESET;
			gate_control           <= gsbt_pkg::GATE_RESET;
			overflow_irq_enable    <= 1'b0;
			gate_event_irq_enable  <= 1'b0;
			peripheral_irq_enable  <= 1'b0;
			global_irq_enable      <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				timer_control_register <= reg_wr_data & gsbt_pkg::CTRL_RW_MASK;
			end
			if (wr_gate) begin
				gate_control <= gate_sw;
				gate_control[gsbt_pkg::GATE_ARMED] <= sw_arm;
			end else if (gate_fall && single_pulse_mode) begin
				gate_control[gsbt_pkg::GATE_ARMED] <= 1'b0;
			end
			if (wr_mask) begin
				overflow_irq_enable   <= reg_wr_data[gsbt_pkg::ST_OVF];
				gate_event_irq_enable <= reg_wr_data[gsbt_pkg::ST_GATE];
			end
			if (wr_irq_ctrl) begin
				peripheral_irq_enable <= reg_wr_data[gsbt_pkg::IC_PERIPH];
				global_irq_enable     <= reg_wr_data[gsbt_pkg::IC_GLOBAL];
			end
		end
	end

	// ****************************************
	// interrupt, wake and oscillator
	// ****************************************
	wire logic ovf_req  = overflow_flag && overflow_irq_enable && timer_run;
	wire logic gate_req = gate_event_flag && gate_event_irq_enable;
	assign irq      = global_irq_enable && peripheral_irq_enable && (ovf_req || gate_req);
	assign wake     = sleep_mode && peripheral_irq_enable && ovf_req;
	assign ext_osc_enable = timer_run && (clock_source_select == gsbt_pkg::CS_EXT_PIN);

	// ****************************************
	// read port
	// ****************************************
	assign next_rd_data =
		(reg_addr == gsbt_pkg::OFS_CTRL)   ? timer_control_register :
		(reg_addr == gsbt_pkg::OFS_GATE)   ? {gate_control[7:3], gate_level, 2'h0} :
		(reg_addr == gsbt_pkg::OFS_CNT_LO) ? count[7:0] :
		(reg_addr == gsbt_pkg::OFS_CNT_HI) ? count[15:8] :
		(reg_addr == gsbt_pkg::OFS_STATUS) ? {6'h00, gate_event_flag, overflow_flag} :
		(reg_addr == gsbt_pkg::OFS_MASK)   ? {6'h00, gate_event_irq_enable, overflow_irq_enable} :
		(reg_addr == gsbt_pkg::OFS_IRQ_CTRL) ? {6'h00, global_irq_enable, peripheral_irq_enable} :
		8'h00;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rd_data <= 8'h00;
		end else begin
			reg_rd_data <= reg_rd ? next_rd_data : 8'h00;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_gate_fall_sets;
		@(posedge core_clk) disable iff (!rst_b)
		$fell(gate_level) |-> gate_event_flag;
	endproperty
	a_gate_fall_sets: assert property (p_gate_fall_sets) else $error("gate fall missed flag");

	property p_gate_irq_cause;
		@(posedge core_clk) disable iff (!rst_b)
		(irq && !ovf_req) |-> (gate_event_flag && gate_event_irq_enable);
	endproperty
	a_gate_irq_cause: assert property (p_gate_irq_cause) else $error("gate irq without cause");

	property p_gate_flag_ungated;
		@(posedge core_clk) disable iff (!rst_b)
		(!gating_on && gate_level && !gate_value) |=> gate_event_flag;
	endproperty
	a_gate_flag_ungated: assert property (p_gate_flag_ungated) else $error("flag idle ungated");

	property p_wrap;
		@(posedge core_clk) disable iff (!rst_b)
		(inc && count == 16'hffff && !reg_wr) |=> (count == 16'h0000 && overflow_flag);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter wrap wrong");

	property p_ovf_irq_cause;
		@(posedge core_clk) disable iff (!rst_b)
		(irq && !gate_req) |->
			(timer_run && overflow_irq_enable && peripheral_irq_enable && global_irq_enable);
	endproperty
	a_ovf_irq_cause: assert property (p_ovf_irq_cause) else $error("overflow irq ungated");

	property p_sleep_hold;
		@(posedge core_clk) disable iff (!rst_b)
		(sleep_mode && !(clock_source_select == 2'h2 && sync_bypass) && !reg_wr)
			|=> $stable(count);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

	property p_sleep_wake;
		@(posedge core_clk) disable iff (!rst_b)
		(sleep_mode && overflow_flag && overflow_irq_enable && timer_run && peripheral_irq_enable)
			|-> wake;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("no wake on overflow");

	property p_pulse_done;
		@(posedge core_clk) disable iff (!rst_b)
		(single_pulse_mode && pulse_acquire_armed && gate_fall && !wr_gate)
			|=> (!pulse_acquire_armed && gate_event_flag);
	endproperty
	a_pulse_done: assert property (p_pulse_done) else $error("armed bit not cleared");

	property p_stop_clears_toggle;
		@(posedge core_clk) disable iff (!rst_b)
		!timer_run |=> (!toggle_ff && $stable(count)) or $past(reg_wr);
	endproperty
	a_stop_clears_toggle: assert property (p_stop_clears_toggle) else $error("stopped timer moved");

	property p_ctrl_reserved;
		@(posedge core_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == 3'h0) |=> (reg_rd_data[3] == 1'b0 && reg_rd_data[1] == 1'b0);
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bit set");
endmodule

// *** bench/gsbt_timer_tb.sv ***
// Purpose: self-checking bench for the gated 16-bit timer
// Assumes: register port as in gsbt_pkg, one 40 MHz core clock
// Notes:   counts are checked inside a small window where start and stop write latency blurs them
`timescale 1ns/1ps
`define chk_eq(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module gsbt_timer_tb;
	// ****************************************
	// signals
	// ****************************************
	logic                            core_clk;
	logic                            rst_b;
	logic [gsbt_pkg::ADDR_W-1:0]     reg_addr;
	logic [gsbt_pkg::DATA_W-1:0]     reg_wr_data;
	logic                            reg_wr;
	logic                            reg_rd;
	logic [gsbt_pkg::DATA_W-1:0]     reg_rd_data;
	logic                            external_clock_pin;
	logic                            low_freq_internal_osc;
	logic                            gate_pin;
	logic                            sleep_mode;
	logic                            irq;
	logic                            wake;
	logic                            ext_osc_enable;
	int                              n_mismatch;
	int                              checks;
	logic [7:0]                      rd_val;
	logic [7:0]                      held;

	gsbt_timer dut (
		.core_clk              (core_clk),
		.rst_b                 (rst_b),
		.reg_addr              (reg_addr),
		.reg_wr_data           (reg_wr_data),
		.reg_wr                (reg_wr),
		.reg_rd                (reg_rd),
		.reg_rd_data           (reg_rd_data),
		.external_clock_pin    (external_clock_pin),
		.low_freq_internal_osc (low_freq_internal_osc),
		.gate_pin              (gate_pin),
		.sleep_mode            (sleep_mode),
		.irq                   (irq),
		.wake                  (wake),
		.ext_osc_enable        (ext_osc_enable)
	);

	initial begin
		core_clk = 1'b0;
	end
	always #12.5 core_clk = ~core_clk;

	// ****************************************
	// bus tasks
	// ****************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr      <= 1'b1;
		reg_addr    <= a;
		reg_wr_data <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rd_data;
	endtask

	task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
		rd(a);
		`chk_eq(rd_val, exp)
	endtask

	// rising edges on the external count pin
	task automatic pulse_ext(input int n);
		repeat (n) begin
			external_clock_pin <= 1'b1;
			cyc(4);
			external_clock_pin <= 1'b0;
			cyc(4);
		end
	endtask

	task automatic pulse_lf(input int n);
		repeat (n) begin
			low_freq_internal_osc <= 1'b1;
			cyc(4);
			low_freq_internal_osc <= 1'b0;
			cyc(4);
		end
	endtask

	task automatic gate_pulse();
		@(posedge core_clk);
		gate_pin <= 1'b1;
		cyc(8);
		gate_pin <= 1'b0;
		cyc(8);
	endtask

	// run the system source for a fixed span and check the count window
	task automatic run_span(input logic [1:0] cs, input logic [1:0] ps, input int div);
		wr(3'h2, 8'h00);
		wr(3'h3, 8'h00);
		wr(3'h0, {cs, ps, 4'h1});
		cyc(64);
		wr(3'h0, {cs, ps, 4'h0});
		rd(3'h2);
		`chk_eq((rd_val >= 64 / div - 1) && (rd_val <= 64 / div + 3), 1'b1)
	endtask

	task automatic report_and_stop();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		report_and_stop();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		n_mismatch = 0;
		checks = 0;
		rst_b = 1'b0;
		reg_addr = 3'h0;
		reg_wr_data = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		external_clock_pin = 1'b0;
		low_freq_internal_osc = 1'b0;
		gate_pin = 1'b0;
		sleep_mode = 1'b0;
		cyc(2);
		rst_b <= 1'b1;
		cyc(6);
		// reset values, unused bits, unmapped index
		rdchk(3'h0, 8'h00);
		rdchk(3'h4, 8'h00);
		wr(3'h0, 8'hfa);
		rdchk(3'h0, 8'hf0);
		wr(3'h0, 8'h0a);
		rdchk(3'h0, 8'h00);
		wr(3'h7, 8'hff);
		rdchk(3'h7, 8'h00);
		// source and prescale selection
		run_span(2'h1, 2'h0, 1);
		run_span(2'h1, 2'h1, 2);
		run_span(2'h1, 2'h2, 4);
		run_span(2'h1, 2'h3, 8);
		run_span(2'h0, 2'h0, 4);
		// stopped timer holds its count
		rd(3'h2);
		held = rd_val;
		cyc(20);
		rdchk(3'h2, held);
		// low-frequency oscillator source
		wr(3'h2, 8'h00);
		wr(3'h0, 8'hc1);
		pulse_lf(3);
		wr(3'h0, 8'hc0);
		rdchk(3'h2, 8'h03);
		// rollover and overflow interrupt
		wr(3'h2, 8'hff);
		wr(3'h3, 8'hff);
		rdchk(3'h4, 8'h00);
		wr(3'h0, 8'h41);
		cyc(4);
		wr(3'h0, 8'h40);
		rdchk(3'h4, 8'h01);
		rdchk(3'h3, 8'h00);
		rd(3'h2);
		`chk_eq((rd_val >= 8'h01) && (rd_val <= 8'h08), 1'b1)
		wr(3'h5, 8'h01);
		wr(3'h6, 8'h03);
		#1 `chk_eq(irq, 1'b0)
		wr(3'h0, 8'h81);
		#1 `chk_eq(irq, 1'b1)
		wr(3'h6, 8'h01);
		#1 `chk_eq(irq, 1'b0)
		wr(3'h6, 8'h02);
		#1 `chk_eq(irq, 1'b0)
		wr(3'h6, 8'h03);
		wr(3'h5, 8'h00);
		#1 `chk_eq(irq, 1'b0)
		wr(3'h5, 8'h01);
		cyc(30);
		rdchk(3'h4, 8'h01);
		`chk_eq(irq, 1'b1)
		wr(3'h4, 8'h01);
		#1 `chk_eq(irq, 1'b0)
		rdchk(3'h4, 8'h00);
		// external pin counting awake, synchronised
		wr(3'h2, 8'h00);
		wr(3'h3, 8'h00);
		pulse_ext(3);
		rdchk(3'h2, 8'h03);
		// asleep: synchronised pin and system source must not count
		wr(3'h2, 8'h00);
		sleep_mode <= 1'b1;
		pulse_ext(3);
		`chk_eq(ext_osc_enable, 1'b1)
		rdchk(3'h2, 8'h00);
		wr(3'h0, 8'h45);
		cyc(40);
		rdchk(3'h2, 8'h00);
		// asleep: unsynchronised pin counts and overflow wakes
		wr(3'h0, 8'h84);
		#1 `chk_eq(ext_osc_enable, 1'b0)
		wr(3'h2, 8'hfe);
		wr(3'h3, 8'hff);
		wr(3'h6, 8'h01);
		wr(3'h0, 8'h85);
		pulse_ext(1);
		`chk_eq(wake, 1'b0)
		pulse_ext(1);
		`chk_eq(wake, 1'b1)
		`chk_eq(ext_osc_enable, 1'b1)
		`chk_eq(irq, 1'b0)
		rdchk(3'h2, 8'h00);
		wr(3'h6, 8'h03);
		#1 `chk_eq(irq, 1'b1)
		wr(3'h4, 8'h01);
		#1 `chk_eq(wake, 1'b0)
		cyc(1);
		sleep_mode <= 1'b0;
		wr(3'h0, 8'h00);
		wr(3'h5, 8'h00);
		// gate level and gate event with gating off
		wr(3'h1, 8'h40);
		// polarity change drops the gate level: a genuine fall
		rdchk(3'h4, 8'h02);
		wr(3'h4, 8'h02);
		gate_pin <= 1'b1;
		cyc(8);
		rdchk(3'h1, 8'h44);
		rdchk(3'h4, 8'h00);
		cyc(1);
		gate_pin <= 1'b0;
		cyc(8);
		rdchk(3'h1, 8'h40);
		rdchk(3'h4, 8'h02);
		wr(3'h5, 8'h02);
		#1 `chk_eq(irq, 1'b1)
		wr(3'h5, 8'h00);
		#1 `chk_eq(irq, 1'b0)
		wr(3'h5, 8'h02);
		wr(3'h4, 8'h02);
		#1 `chk_eq(irq, 1'b0)
		// toggle gate: stopping the timer clears the toggle
		wr(3'h1, 8'h60);
		wr(3'h0, 8'h01);
		gate_pulse();
		rdchk(3'h1, 8'h64);
		wr(3'h0, 8'h00);
		cyc(2);
		rdchk(3'h1, 8'h60);
		rdchk(3'h4, 8'h02);
		wr(3'h4, 8'h02);
		// single-pulse acquisition
		wr(3'h1, 8'hd8);
		rdchk(3'h1, 8'hd8);
		gate_pulse();
		rdchk(3'h1, 8'hd0);
		rdchk(3'h4, 8'h02);
		`chk_eq(irq, 1'b1)
		report_and_stop();
	end
endmodule
